//--- tpm_pkg.sv
/*
  Constants for the 16-bit waveform timer: register indexes, control field
  positions, reset values and the counter reload values of the pulse modes.
  Assumes an 8-bit register port with a 4-bit register index.
*/
package tpm_pkg;
  // Register indexes on the byte port
  localparam logic [3:0] A_CTRL1 = 4'h0;
  localparam logic [3:0] A_CTRL2 = 4'h1;
  localparam logic [3:0] A_STAT = 4'h2;
  localparam logic [3:0] A_IC1H = 4'h3;
  localparam logic [3:0] A_IC1L = 4'h4;
  localparam logic [3:0] A_OC1H = 4'h5;
  localparam logic [3:0] A_OC1L = 4'h6;
  localparam logic [3:0] A_OC2H = 4'h7;
  localparam logic [3:0] A_OC2L = 4'h8;
  localparam logic [3:0] A_CNTH = 4'h9;
  localparam logic [3:0] A_CNTL = 4'ha;
  localparam logic [3:0] A_IC2H = 4'hb;
  localparam logic [3:0] A_IC2L = 4'hc;
  // Control register 1 fields
  localparam int B_CAPTURE_IRQ_ENABLE = 7;
  localparam int B_COMPARE_PIN_ENABLE = 6;
  localparam int B_TOIE = 5;
  localparam int B_FORCE2 = 4;
  localparam int B_FORCE1 = 3;
  localparam int B_LVL2 = 2;
  localparam int B_EDGE1 = 1;
  localparam int B_LVL1 = 0;
  // Control register 2 fields
  localparam int B_OC1E = 7;
  localparam int B_OC2E = 6;
  localparam int B_OPM = 5;
  localparam int B_PWM = 4;
  localparam int B_CC_HI = 3;
  localparam int B_CC_LO = 2;
  localparam int B_EDGE2 = 1;
  localparam int B_EXEDG = 0;
  // Status flag vector order: capture 1, compare 1, overflow, capture 2, compare 2
  localparam int F_IC1 = 4;
  localparam int F_OC1 = 3;
  localparam int F_TOF = 2;
  localparam int F_IC2 = 1;
  localparam int F_OC2 = 0;
  localparam int NFLAG = 5;
  // Clock select codes and prescaler masks
  localparam logic [1:0] CC_DIV4 = 2'h0;
  localparam logic [1:0] CC_DIV2 = 2'h1;
  localparam logic [1:0] CC_DIV8 = 2'h2;
  localparam logic [1:0] CC_EXT = 2'h3;
  localparam logic [2:0] M_DIV2 = 3'h1;
  localparam logic [2:0] M_DIV4 = 3'h3;
  localparam logic [2:0] M_DIV8 = 3'h7;
  // Reset and reload values
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [15:0] CNT_RST = 16'h0000;
  localparam logic [15:0] CNT_MAX = 16'hffff;
  localparam logic [15:0] CNT_RELOAD = 16'hfffc;
  localparam logic [15:0] IC_TRIG_VAL = 16'hfffd;
  localparam logic [15:0] OC_RST = 16'h8000;
  localparam logic [15:0] IC_RST = 16'h0000;
  localparam logic [7:0] RD_NONE = 8'h00;
endpackage

//--- tpm_edge_if.sv
/*
  Carrier between the timer core and its edge detectors: a pin level, the
  selected edge and the one-cycle detect pulse.
  Assumes the pin level is synchronous to the timer clock.
*/
`timescale 1ns/1ps
interface tpm_edge_if;
  logic level;
  logic rise_sel;
  logic pulse;
  modport det (input level, input rise_sel, output pulse);
  modport user (output level, output rise_sel, input pulse);
endinterface

//--- tpm_edge_det.sv
/*
  Edge detector: pulses for one cycle on the selected transition of a pin.
  Assumes a synchronous pin level; keeps running during halt so that an
  edge seen in halt can arm a capture.
*/
`timescale 1ns/1ps
module tpm_edge_det
  import tpm_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_reset_n,
  tpm_edge_if.det port
);
  logic prev;

  // Previous pin level
  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
      prev <= 1'b0;
    else
      prev <= port.level;
  end

  // Rising or falling transition as selected
  assign port.pulse = port.rise_sel ? (port.level & ~prev) : (~port.level & prev);
endmodule

//--- tpm_timer.sv
/*
  16-bit free-running timer with forced compare, one-pulse and double-buffered
  PWM waveform modes, captures, and wait/halt behaviour.
  Assumes synchronous pins, an 8-bit register port with data one cycle after
  the read strobe, and a system that drives halt, wait and the global mask.
*/
//
// Behaviour
// - Force bit set copies its level bit onto the compare pin continuously.
// - A forced pin change never sets a compare flag.
// - Force bits do nothing in one-pulse or PWM mode.
// - One-pulse trigger edge: counter FFFCh, pin takes level 2, capture 1 flag, FFFDh.
// - The one-pulse trigger flag requests an interrupt when capture enable is set.
// - Capture flag clears after status read then low-byte access.
// - One-pulse: counter equal to compare 1 puts level 1 on the pin.
// - One-pulse: compare flag 1 never set; compare flag 2 still works.
// - One-pulse and PWM both selected means PWM only.
// - Equal level bits give a constant pin in pulse modes.
// - One-pulse: input 1 captures nothing, input 2 still captures.
// - One-pulse: compare 2 flags time but drives no pin.
// - Pulse and period last compare value plus five ticks.
// - PWM: compare 2 match reloads counter with FFFCh.
// - PWM: compare writes take effect at the compare 2 match.
// - PWM: pin takes level 1 on compare 1, level 2 on compare 2.
// - High byte write disables that compare until its low byte is written.
// - PWM: compare flags never set by hardware.
// - PWM: compare 2 match sets capture flag 1, interrupt if enabled and unmasked.
// - PWM: input 1 disconnected, input 2 still captures.
// - Wait: timer runs on; enabled interrupt wakes the device.
// - Halt freezes registers; counting resumes from held count after interrupt wake.
// - Capture edge in halt arms; wake sets flag and captures count.
// - Clock select 00 /4, 01 /2, 10 /8, 11 external edge.
`timescale 1ns/1ps
module tpm_timer
  import tpm_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic [3:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  input wire logic i_capture_input_pin_1,
  input wire logic i_capture_input_pin_2,
  input wire logic i_ext_clk,
  input wire logic i_halt,
  input wire logic i_wait,
  input wire logic i_irq_mask,
  output logic o_compare_pin_1,
  output logic o_compare_pin_1_oe,
  output logic o_compare_pin_2,
  output logic o_compare_pin_2_oe,
  output logic o_timer_irq,
  output logic o_wait_wake
);
  logic [7:0] ctrl1;
  logic [7:0] ctrl2;
  logic [15:0] cnt;
  logic [2:0] div;
  logic [15:0] cap1;
  logic [15:0] cap2;
  logic [15:0] oc1_wr;
  logic [15:0] oc2_wr;
  logic [15:0] oc1_act;
  logic [15:0] oc2_act;
  logic oc1_inh;
  logic oc2_inh;
  logic cap1_inh;
  logic cap2_inh;
  logic [NFLAG-1:0] flags;
  logic [NFLAG-1:0] seen;
  logic [1:0] arm;
  logic halt_q;
  logic pin1;
  logic pin2;
  logic [7:0] rd_val;

  //////////////////////////////////////////////////////////////////////////////
  // Edge detectors for the two capture pins and the external clock
  tpm_edge_if e1 ();
  tpm_edge_if e2 ();
  tpm_edge_if ex ();
  assign e1.level = i_capture_input_pin_1;
  assign e1.rise_sel = ctrl1[B_EDGE1];
  assign e2.level = i_capture_input_pin_2;
  assign e2.rise_sel = ctrl2[B_EDGE2];
  assign ex.level = i_ext_clk;
  assign ex.rise_sel = ctrl2[B_EXEDG];
  tpm_edge_det u_edge1 (.i_clk(i_clk), .i_reset_n(i_reset_n), .port(e1));
  tpm_edge_det u_edge2 (.i_clk(i_clk), .i_reset_n(i_reset_n), .port(e2));
  tpm_edge_det u_edgex (.i_clk(i_clk), .i_reset_n(i_reset_n), .port(ex));

  //////////////////////////////////////////////////////////////////////////////
  // Mode decode; PWM wins over one-pulse
  wire pwm_mode = ctrl2[B_PWM];
  wire opm_mode = ctrl2[B_OPM] & ~pwm_mode;
  wire norm_mode = ~opm_mode & ~pwm_mode;
  wire run = ~i_halt;
  wire wake = halt_q & ~i_halt;
  wire [1:0] cc = ctrl2[B_CC_HI:B_CC_LO];
  wire lvl1 = ctrl1[B_LVL1];
  wire lvl2 = ctrl1[B_LVL2];

  // Tick selection from the prescaler or the external clock edge
  wire [2:0] div_mask = (cc == CC_DIV2) ? M_DIV2 : (cc == CC_DIV8) ? M_DIV8 : M_DIV4;
  wire tick = run & ((cc == CC_EXT) ? ex.pulse : ((div & div_mask) == div_mask));

  // Compare matches, suppressed while a high byte write is pending
  wire hit1 = tick & (cnt == oc1_act) & ~oc1_inh;
  wire hit2 = tick & (cnt == oc2_act) & ~oc2_inh;
  wire trig = run & opm_mode & e1.pulse;
  wire cap1_take = run & norm_mode & e1.pulse & ~cap1_inh;
  wire cap2_take = run & e2.pulse & ~cap2_inh;
  wire reload = trig | (pwm_mode & hit2);

  // Register access decode
  wire wr_ctrl1 = i_wr & (i_addr == A_CTRL1);
  wire wr_ctrl2 = i_wr & (i_addr == A_CTRL2);
  wire rd_stat = i_rd & (i_addr == A_STAT);
  wire acc = i_wr | i_rd;
  wire wr_oc1h = i_wr & (i_addr == A_OC1H);
  wire wr_oc1l = i_wr & (i_addr == A_OC1L);
  wire wr_oc2h = i_wr & (i_addr == A_OC2H);
  wire wr_oc2l = i_wr & (i_addr == A_OC2L);
  wire [NFLAG-1:0] low_acc = {acc & (i_addr == A_IC1L), acc & (i_addr == A_OC1L),
    i_rd & (i_addr == A_CNTL), acc & (i_addr == A_IC2L), acc & (i_addr == A_OC2L)};

  // Flag set terms
  wire [NFLAG-1:0] flag_set;
  assign flag_set[F_IC1] = trig | cap1_take | (run & pwm_mode & hit2) | (wake & arm[0]);
  assign flag_set[F_OC1] = run & norm_mode & hit1;
  assign flag_set[F_TOF] = tick & ~reload & (cnt == CNT_MAX);
  assign flag_set[F_IC2] = cap2_take | (wake & arm[1]);
  assign flag_set[F_OC2] = run & ~pwm_mode & hit2;
  wire [NFLAG-1:0] flag_clr = low_acc & seen;
  wire [NFLAG-1:0] next_flags = (flags & ~flag_clr) | flag_set;

  //////////////////////////////////////////////////////////////////////////////
  // Control registers
  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      ctrl1 <= CTRL_RST;
      ctrl2 <= CTRL_RST;
    end
    else
    begin
      if (wr_ctrl1)
        ctrl1 <= i_wdata;
      if (wr_ctrl2)
        ctrl2 <= i_wdata;
    end
  end

  // Prescaler and counter, frozen during halt
  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      div <= 3'h0;
      cnt <= CNT_RST;
    end
    else if (run)
    begin
      div <= div + 3'h1;
      if (reload)
        cnt <= CNT_RELOAD;
      else if (tick)
        cnt <= cnt + 16'h0001;
    end
  end

  // Status flags; a set in the clearing cycle wins
  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      flags <= '0;
      seen <= '0;
    end
    else
    begin
      flags <= next_flags;
      seen <= rd_stat ? flags : (seen & ~flag_clr);
    end
  end

  // Halt capture arming and exit detection
  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      halt_q <= 1'b0;
      arm <= 2'h0;
    end
    else
    begin
      halt_q <= i_halt;
      if (wake)
        arm <= 2'h0;
      else if (i_halt)
        arm <= arm | {e2.pulse & ~cap2_inh, e1.pulse & norm_mode & ~cap1_inh};
    end
  end

  // Capture registers and their high-byte read inhibit
  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      cap1 <= IC_RST;
      cap2 <= IC_RST;
      cap1_inh <= 1'b0;
      cap2_inh <= 1'b0;
    end
    else
    begin
      if (trig)
        cap1 <= IC_TRIG_VAL;
      else if (cap1_take | (wake & arm[0]))
        cap1 <= cnt;
      if (cap2_take | (wake & arm[1]))
        cap2 <= cnt;
      if (i_rd & (i_addr == A_IC1H))
        cap1_inh <= 1'b1;
      else if (i_rd & (i_addr == A_IC1L))
        cap1_inh <= 1'b0;
      if (i_rd & (i_addr == A_IC2H))
        cap2_inh <= 1'b1;
      else if (i_rd & (i_addr == A_IC2L))
        cap2_inh <= 1'b0;
    end
  end

  // Compare registers: written copies, active copies and write inhibit
  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      oc1_wr <= OC_RST;
      oc2_wr <= OC_RST;
      oc1_inh <= 1'b0;
      oc2_inh <= 1'b0;
    end
    else
    begin
      if (wr_oc1h)
        oc1_wr[15:8] <= i_wdata;
      if (wr_oc1l)
        oc1_wr[7:0] <= i_wdata;
      if (wr_oc2h)
        oc2_wr[15:8] <= i_wdata;
      if (wr_oc2l)
        oc2_wr[7:0] <= i_wdata;
      oc1_inh <= wr_oc1h | (oc1_inh & ~wr_oc1l);
      oc2_inh <= wr_oc2h | (oc2_inh & ~wr_oc2l);
    end
  end

  // Active compare values follow writes, except in PWM where they load per period
  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      oc1_act <= OC_RST;
      oc2_act <= OC_RST;
    end
    else if (!pwm_mode || hit2)
    begin
      oc1_act <= oc1_wr;
      oc2_act <= oc2_wr;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Compare pin latches, low from reset
  wire force1 = norm_mode & ctrl1[B_FORCE1];
  wire force2 = norm_mode & ctrl1[B_FORCE2];
  wire [1:0] pin1_src = {opm_mode & trig | pwm_mode & hit2,
    (opm_mode | pwm_mode) & hit1 | norm_mode & (hit1 | force1)};
  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      pin1 <= 1'b0;
      pin2 <= 1'b0;
    end
    else if (run)
    begin
      if (pin1_src[1])
        pin1 <= lvl2;
      else if (pin1_src[0])
        pin1 <= lvl1;
      if (norm_mode & (hit2 | force2))
        pin2 <= lvl2;
    end
  end
  assign o_compare_pin_1 = pin1;
  assign o_compare_pin_2 = pin2;
  assign o_compare_pin_1_oe = ctrl2[B_OC1E];
  assign o_compare_pin_2_oe = ctrl2[B_OC2E];

  // Interrupt request and wait wake-up
  wire irq_src = (ctrl1[B_CAPTURE_IRQ_ENABLE] & (flags[F_IC1] | flags[F_IC2]))
    | (ctrl1[B_COMPARE_PIN_ENABLE] & (flags[F_OC1] | flags[F_OC2])) | (ctrl1[B_TOIE] & flags[F_TOF]);
  assign o_timer_irq = irq_src & ~i_irq_mask;
  assign o_wait_wake = i_wait & o_timer_irq;

  //////////////////////////////////////////////////////////////////////////////
  // Read data selection
  always_comb
  begin
    case (i_addr)
      A_CTRL1: rd_val = ctrl1;
      A_CTRL2: rd_val = ctrl2;
      A_STAT: rd_val = {flags, 3'h0};
      A_IC1H: rd_val = cap1[15:8];
      A_IC1L: rd_val = cap1[7:0];
      A_OC1H: rd_val = oc1_wr[15:8];
      A_OC1L: rd_val = oc1_wr[7:0];
      A_OC2H: rd_val = oc2_wr[15:8];
      A_OC2L: rd_val = oc2_wr[7:0];
      A_CNTH: rd_val = cnt[15:8];
      A_CNTL: rd_val = cnt[7:0];
      A_IC2H: rd_val = cap2[15:8];
      A_IC2L: rd_val = cap2[7:0];
      default: rd_val = RD_NONE;
    endcase
  end

  // Read data register, valid the cycle after the strobe
  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
      o_rdata <= RD_NONE;
    else
      o_rdata <= i_rd ? rd_val : RD_NONE;
  end

  //////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);

  force_pin_a: assert property (run && force1 && !hit1 |=> pin1 == $past(lvl1))
    else $error("forced level not on pin 1");
  force_noflag_a: assert property (force1 && !hit1 && !flags[F_OC1] |=> !flags[F_OC1])
    else $error("force set compare flag 1");
  opm_trig_a: assert property (trig |=> cnt == CNT_RELOAD && cap1 == IC_TRIG_VAL
    && flags[F_IC1] && pin1 == $past(lvl2)) else $error("one-pulse trigger wrong");
  opm_end_a: assert property (opm_mode && hit1 && !trig |=> pin1 == $past(lvl1))
    else $error("one-pulse end level wrong");
  pulse_noocf_a: assert property (!norm_mode && !flags[F_OC1] |=> !flags[F_OC1])
    else $error("compare flag 1 set in pulse mode");
  pwm_reload_a: assert property (pwm_mode && hit2 |=> cnt == CNT_RELOAD && flags[F_IC1])
    else $error("PWM period reload wrong");
  pwm_buffer_a: assert property (pwm_mode && !hit2 && $stable(pwm_mode) |=> $stable(oc1_act))
    else $error("PWM compare changed mid period");
  hi_inhibit_a: assert property (wr_oc1h ##1 !wr_oc1l |-> !hit1)
    else $error("compare 1 active after high write");
  pwm_noocf2_a: assert property (pwm_mode && !flags[F_OC2] |=> !flags[F_OC2])
    else $error("compare flag 2 set in PWM");
  halt_freeze_a: assert property (i_halt && $past(i_halt) |=> $stable(cnt))
    else $error("counter moved in halt");
  div2_tick_a: assert property (run && cc == CC_DIV2 && tick ##1 run && cc == CC_DIV2 |-> !tick)
    else $error("divide by 2 ticks too often");

  opm_cov_c: cover property (opm_mode && trig ##[1:40] opm_mode && hit1);
  pwm_cov_c: cover property (pwm_mode && hit2 ##[1:60] pwm_mode && hit1);
  halt_cov_c: cover property (wake && arm[1]);
endmodule

//--- tpm_partner.sv
/*
  Far side of the timer: source of the capture pins and the external clock,
  and the load on compare pin 1 that measures high time and period.
  Assumes the bench calls the tasks from its clocked sequence.
*/
`timescale 1ns/1ps
module tpm_partner
(
  input wire logic i_clk,
  input wire logic i_load,
  output logic o_cap1,
  output logic o_cap2,
  output logic o_ext_clk,
  output logic [15:0] o_high_len,
  output logic [15:0] o_period
);
  logic last = 1'b0;
  logic [15:0] hi = 16'h0000;
  logic [15:0] per = 16'h0000;
  initial
  begin
    o_cap1 = 1'b0;
    o_cap2 = 1'b0;
    o_ext_clk = 1'b0;
  end
  ////////////////////////////////////////////////////////////////////////////
  // Rising edge on one capture pin, held four cycles, then back low
  task pulse(input bit two);
    @(posedge i_clk);
    if (two) o_cap2 <= 1'b1; else o_cap1 <= 1'b1;
    repeat (4) @(posedge i_clk);
    if (two) o_cap2 <= 1'b0; else o_cap1 <= 1'b0;
  endtask
  // External clock runs only inside a burst, six cycles a period
  task ext_edges(input int n);
    repeat (n)
    begin
      @(posedge i_clk);
      o_ext_clk <= 1'b1;
      repeat (3) @(posedge i_clk);
      o_ext_clk <= 1'b0;
      repeat (2) @(posedge i_clk);
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Load monitor: high samples up to each fall, cycles between rises
  always @(posedge i_clk)
  begin
    last <= i_load;
    hi <= i_load ? hi + 16'h0001 : 16'h0000;
    per <= (i_load && !last) ? 16'h0001 : per + 16'h0001;
    if (!i_load && last) o_high_len <= hi;
    if (i_load && !last) o_period <= per;
  end
endmodule

//--- timer_pulse_pwm_modes_test.sv
/*
  Self-checking bench for the waveform timer: register port tasks, one task
  per scenario, and a cycle ceiling.
  Assumes the partner model drives the pins and measures compare pin 1.
*/
`timescale 1ns/1ps
module timer_pulse_pwm_modes_test;
  import tpm_pkg::*;
  logic i_clk = 1'b0;
  logic i_reset_n = 1'b0;
  logic [3:0] i_addr = 4'h0;
  logic [7:0] i_wdata = 8'h00;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic i_halt = 1'b0;
  logic i_wait = 1'b0;
  logic i_irq_mask = 1'b0;
  logic [7:0] o_rdata;
  logic o_compare_pin_1, o_compare_pin_1_oe, o_compare_pin_2, o_compare_pin_2_oe;
  logic o_timer_irq, o_wait_wake, cap1, cap2, ext_clk;
  logic [15:0] high_len, period;
  logic [7:0] a, b, st;
  int failures = 0;
  int tests_run = 0;
  int cycles = 0;
  // Pulled low when the pin is not enabled
  wire load = o_compare_pin_1_oe ? o_compare_pin_1 : 1'b0;
  tpm_timer DUT (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_capture_input_pin_1(cap1),
    .i_capture_input_pin_2(cap2), .i_ext_clk(ext_clk), .i_halt(i_halt), .i_wait(i_wait),
    .i_irq_mask(i_irq_mask), .o_compare_pin_1(o_compare_pin_1),
    .o_compare_pin_1_oe(o_compare_pin_1_oe), .o_compare_pin_2(o_compare_pin_2),
    .o_compare_pin_2_oe(o_compare_pin_2_oe), .o_timer_irq(o_timer_irq),
    .o_wait_wake(o_wait_wake));
  tpm_partner MDL (.i_clk(i_clk), .i_load(load), .o_cap1(cap1), .o_cap2(cap2),
    .o_ext_clk(ext_clk), .o_high_len(high_len), .o_period(period));
  always #5 i_clk = ~i_clk;
  ////////////////////////////////////////////////////////////////////////////
  // Closing report, comparison and register port tasks
  task print_verdict;
    if (failures == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task check(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask
  task wr(input logic [3:0] ad, input logic [7:0] d);
    @(posedge i_clk);
    i_wr <= 1'b1;
    i_addr <= ad;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe
  task rd(input logic [3:0] ad, output logic [7:0] d);
    @(posedge i_clk);
    i_rd <= 1'b1;
    i_addr <= ad;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1 d = o_rdata;
  endtask
  task reset;
    @(posedge i_clk);
    i_reset_n <= 1'b0;
    i_halt <= 1'b0;
    i_wait <= 1'b0;
    i_irq_mask <= 1'b0;
    repeat (6) @(posedge i_clk);
    i_reset_n <= 1'b1;
  endtask
  task wait_pin(input logic v);
    int n;
    n = 0;
    while (load !== v && n < 300)
    begin
      @(posedge i_clk);
      n++;
    end
    check(load, v);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Scenarios
  task t_reset_values;
    reset;
    rd(A_CTRL1, a); check(a, CTRL_RST);
    rd(A_OC1H, a); check(a, OC_RST[15:8]);
    rd(4'hf, a); check(a, RD_NONE);
    check({o_compare_pin_1, o_compare_pin_1_oe, o_compare_pin_2, o_compare_pin_2_oe,
      o_timer_irq, o_wait_wake}, 6'h00);
  endtask
  task t_force;
    reset;
    wr(A_CTRL2, 8'hc0);
    wr(A_CTRL1, 8'h5d); @(posedge i_clk); #1;
    check({load, o_compare_pin_2, o_compare_pin_2_oe}, 3'b111);
    wr(A_CTRL1, 8'h58); @(posedge i_clk); #1 check({load, o_compare_pin_2}, 2'b00);
    rd(A_STAT, st); check(st & 8'h48, 8'h00);
    check(o_timer_irq, 1'b0);
  endtask
  task t_one_pulse;
    reset;
    wr(A_OC1H, 8'h00); wr(A_OC1L, 8'h0a);
    wr(A_OC2H, 8'h00); wr(A_OC2L, 8'h06);
    wr(A_CTRL2, 8'he4);
    wr(A_CTRL1, 8'h09); repeat (2) @(posedge i_clk); #1 check(load, 1'b0);
    wr(A_CTRL1, 8'h86); repeat (30) @(posedge i_clk); #1 check(o_timer_irq, 1'b0);
    MDL.pulse(1'b0);
    check(o_timer_irq, 1'b1);
    wait_pin(1'b0); @(posedge i_clk); #1;
    check(high_len >= 16'd29 && high_len <= 16'd30, 16'h1);
    check(o_compare_pin_2, 1'b0);
    rd(A_STAT, st); check(st & 8'he8, 8'ha8);
    rd(A_IC1H, a); check(a, IC_TRIG_VAL[15:8]);
    rd(A_IC1L, a); check(a, IC_TRIG_VAL[7:0]);
    rd(A_STAT, st); check(st[7], 1'b0);
  endtask
  task t_pwm;
    reset;
    wr(A_OC1H, 8'h00); wr(A_OC1L, 8'h05);
    wr(A_OC2H, 8'h00); wr(A_OC2L, 8'h14);
    wr(A_CTRL1, 8'h84); wr(A_CTRL2, 8'hb4);
    wait_pin(1'b1); wait_pin(1'b0); wait_pin(1'b1);
    wr(A_OC1H, 8'h00); wr(A_OC1L, 8'h09);
    MDL.pulse(1'b0);
    wait_pin(1'b0); @(posedge i_clk); #1 check(high_len, 16'd20);
    wait_pin(1'b1); wait_pin(1'b0); @(posedge i_clk); #1;
    check(high_len, 16'd28);
    check(period, 16'd50);
    rd(A_STAT, st); check(st & 8'hc8, 8'h80);
    check(o_timer_irq, 1'b1);
    @(posedge i_clk); i_irq_mask <= 1'b1; #1 check(o_timer_irq, 1'b0);
  endtask
  task t_compare_disable;
    reset;
    wr(A_CTRL2, 8'h84); wr(A_CTRL1, 8'h01);
    wr(A_OC1H, 8'h00); wr(A_OC1L, 8'h20); wr(A_OC1H, 8'h00);
    repeat (100) @(posedge i_clk);
    rd(A_STAT, st); check({st[6], load}, 2'b00);
    wr(A_OC1L, 8'h50); repeat (100) @(posedge i_clk);
    rd(A_STAT, st); check({st[6], load}, 2'b11);
  endtask
  task t_clock_select;
    logic [1:0] cc[3];
    int dv[3];
    cc = '{CC_DIV2, CC_DIV4, CC_DIV8};
    dv = '{2, 4, 8};
    for (int k = 0; k < 3; k++)
    begin
      reset;
      wr(A_CTRL2, {4'h0, cc[k], 2'b00});
      rd(A_CNTL, a); repeat (62) @(posedge i_clk); rd(A_CNTL, b);
      check(8'(b - a), 8'(64 / dv[k]));
    end
    reset;
    wr(A_CTRL2, {4'h0, CC_EXT, 2'b01});
    rd(A_CNTL, a); MDL.ext_edges(10); repeat (2) @(posedge i_clk); rd(A_CNTL, b);
    check(8'(b - a), 8'h0a);
  endtask
  task t_halt_wait;
    reset;
    wr(A_CTRL1, 8'h80); wr(A_CTRL2, 8'h06);
    repeat (20) @(posedge i_clk);
    i_halt <= 1'b1; repeat (2) @(posedge i_clk);
    rd(A_CNTL, a); MDL.pulse(1'b1); repeat (10) @(posedge i_clk);
    rd(A_CNTL, b); check(b, a);
    @(posedge i_clk); i_wait <= 1'b1; i_halt <= 1'b0; repeat (2) @(posedge i_clk); #1;
    check(o_wait_wake, 1'b1);
    rd(A_STAT, st); check(st[4], 1'b1);
    rd(A_IC2L, b); check(b, a);
    repeat (20) @(posedge i_clk); rd(A_CNTL, b); check(b > a, 16'h1);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Cycle ceiling and main sequence
  always @(posedge i_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      failures++;
      print_verdict;
    end
  end
  initial
  begin
    t_reset_values;
    t_force;
    t_one_pulse;
    t_pwm;
    t_compare_disable;
    t_clock_select;
    t_halt_wait;
    print_verdict;
  end
endmodule
